// ### timer_pkg.sv
/*
  Constants shared by the modulo timer: register-file and peripheral
  addresses, field positions, reset values and tick-source codes.
  Assumes a single system clock from which all tick taps are divided.
*/
package timer_pkg;

  localparam int unsigned CNT_W = 8;
  localparam int unsigned RF_ADDR_W = 6;
  localparam int unsigned RF_DATA_W = 4;
  localparam int unsigned PERIPH_ADDR_W = 8;

  // Register-file nibbles
  localparam logic [RF_ADDR_W-1:0] RF_CTRL_ADDR = 6'h33;
  localparam logic [RF_ADDR_W-1:0] RF_IRQ_ADDR = 6'h3F;
  localparam int unsigned RUN_BIT = 3;
  localparam int unsigned CLEAR_BIT = 2;
  localparam int unsigned SEL_HI_BIT = 1;
  localparam int unsigned SEL_LO_BIT = 0;
  localparam int unsigned IRQ_BIT = 0;
  localparam logic [RF_DATA_W-1:0] CTRL_RESET = 4'h8;

  // Peripheral registers behind the transfer buffer
  localparam logic [PERIPH_ADDR_W-1:0] PERIPH_COUNT_ADDR = 8'h05;
  localparam logic [PERIPH_ADDR_W-1:0] PERIPH_LIMIT_ADDR = 8'h06;
  localparam logic [CNT_W-1:0] COUNT_RESET = 8'h00;
  localparam logic [CNT_W-1:0] LIMIT_RESET = 8'hFF;

  // Prescaler taps: log2 of the divide ratios 32, 64, 256
  localparam int unsigned TAP_COUNT = 3;
  localparam int unsigned PRESCALE_W = 8;
  localparam int unsigned TAP_LOG2 [TAP_COUNT] = '{5, 6, 8};

  typedef enum logic [1:0] {
    SRC_DIV32   = 2'b00,
    SRC_DIV64   = 2'b01,
    SRC_DIV256  = 2'b10,
    SRC_CARRIER = 2'b11
  } tick_src_t;

endpackage

// ### timer_tick_if.sv
/*
  Carrier between the timer core and its tick selector: the chosen
  source code and the resulting one-cycle counting tick.
  Assumes both ends run on core_clk.
*/
interface timer_tick_if;
  import timer_pkg::*;
  tick_src_t sel;
  logic      tick;
  modport consumer (output sel, input tick);
  modport source (input sel, output tick);
endinterface

// ### fx_prescaler.sv
/*
  Free-running divider of the system clock; emits one-cycle pulses on
  the falling edge of each divided tap.
  Assumes core_clk is the system clock.
*/
module fx_prescaler (
  // Clock and reset
  input  wire logic                           core_clk,
  input  wire logic                           rstn,
  // Falling-edge pulses of fx/32, fx/64, fx/256
  output logic      [timer_pkg::TAP_COUNT-1:0] tapFall
);
  import timer_pkg::*;

  typedef struct packed {
    logic [PRESCALE_W-1:0] div;
  } pre_state_t;

  pre_state_t st_q;
  pre_state_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.div = st_q.div + 8'h01;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Tap bit falls when all bits below and including it are ones
  for (genvar t = 0; t < TAP_COUNT; t++) begin : g_tap
    assign tapFall[t] = &st_q.div[TAP_LOG2[t]-1:0]; // R13
  end
endmodule // fx_prescaler

// ### tick_select.sv
/*
  Picks the counting tick from the prescaler taps or the carrier input,
  taking the falling edge of the selected source.
  Assumes carrierIn is synchronous to core_clk.
*/
module tick_select (
  // Clock and reset
  input  wire logic                           core_clk,
  input  wire logic                           rstn,
  // Sources
  input  wire logic [timer_pkg::TAP_COUNT-1:0] tapFall,
  input  wire logic                           carrierIn,
  // Towards the timer core
  timer_tick_if.source                        tk
);
  import timer_pkg::*;

  typedef struct packed {
    logic carrierPrev;
  } sel_state_t;

  sel_state_t st_q;
  sel_state_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.carrierPrev = carrierIn;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  always_comb begin
    unique case (tk.sel)
      SRC_DIV32:   tk.tick = tapFall[0]; // R13
      SRC_DIV64:   tk.tick = tapFall[1]; // R13
      SRC_DIV256:  tk.tick = tapFall[2]; // R13
      SRC_CARRIER: tk.tick = st_q.carrierPrev & ~carrierIn; // R13
    endcase
  end
endmodule // tick_select

// ### eight_bit_modulo_timer.sv
/*
  Eight-bit modulo timer: counter, write-only match limit, comparator
  and tick selector, with its control nibble and interrupt request flag
  in the register file and its data registers behind the transfer buffer.
  Assumes register-file and peripheral accesses are one-cycle strobes
  synchronous to core_clk, and carrierIn is synchronous as well.
*/

// Notes on behaviour
// [R1] Counter, limit, comparator and tick selector
// [R2] Run flag starts and stops counting
// [R3] Writing clear flag zeroes counter
// [R4] Two-bit field selects counting clock
// [R5] Peripheral read returns counter value
// [R6] Software cannot load the counter
// [R7] Peripheral write loads match limit
// [R8] Match limit reads back as zero
// [R9] Counter equal limit sets interrupt flag
// [R10] Counter at 05H, resets to 00H
// [R11] Limit at 06H, resets to FFH
// [R12] Software never writes zero limit
// [R13] Codes pick fx/32, fx/64, fx/256, carrier
// [R14] Clear flag reads zero, clears flag too
// [R15] Advances on falling edge while running
// [R16] Wraps to zero tick after match
// [R17] Interrupt flag sticky until cleared
module eight_bit_modulo_timer (
  // Clock and reset
  input  wire logic                                core_clk,
  input  wire logic                                rstn,
  // Register-file nibble access
  input  wire logic [timer_pkg::RF_ADDR_W-1:0]     rfAddr,
  input  wire logic                                rfWrEn,
  input  wire logic [timer_pkg::RF_DATA_W-1:0]     rfWrData,
  input  wire logic                                rfRdEn,
  output logic      [timer_pkg::RF_DATA_W-1:0]     rfRdData,
  // Peripheral access through the transfer buffer
  input  wire logic [timer_pkg::PERIPH_ADDR_W-1:0] periphAddr,
  input  wire logic                                peripheralWriteOp,
  input  wire logic                                peripheralReadOp,
  input  wire logic [timer_pkg::CNT_W-1:0]         transferBufferIn,
  output logic      [timer_pkg::CNT_W-1:0]         transferBufferOut,
  // Carrier generator output used as tick source
  input  wire logic                                carrierIn,
  // Status
  output logic                                     timerMatchIrqFlag
);
  import timer_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0]     count;
    logic [CNT_W-1:0]     limit;
    logic                 countRunFlag;
    tick_src_t            tickSourceSel;
    logic                 irq;
    logic                 matchPrev;
    logic [RF_DATA_W-1:0] rfRd;
    logic [CNT_W-1:0]     periphRd;
  } timer_state_t;

  timer_state_t st_q;
  timer_state_t st_d;

  logic [TAP_COUNT-1:0] tapFall;
  logic                 ctrlWr;
  logic                 clearHit;
  logic                 irqWr;
  logic                 advance;
  logic                 matchEq;
  logic                 matchSet;

  timer_tick_if tk ();

  fx_prescaler u_prescaler (
    .core_clk (core_clk),
    .rstn     (rstn),
    .tapFall  (tapFall)
  );

  tick_select u_tick_select (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .tapFall   (tapFall),
    .carrierIn (carrierIn),
    .tk        (tk.source)
  );

  assign tk.sel = st_q.tickSourceSel; // R4

  always_comb begin
    ctrlWr = rfWrEn && (rfAddr == RF_CTRL_ADDR);
    clearHit = ctrlWr && rfWrData[CLEAR_BIT]; // R3
    irqWr = rfWrEn && (rfAddr == RF_IRQ_ADDR);
    advance = st_q.countRunFlag && tk.tick; // R15
    // Zero limit never raises the flag
    matchEq = (st_q.count == st_q.limit) && (st_q.limit != 8'h00); // R1
    matchSet = matchEq && !st_q.matchPrev; // R9
  end

  always_comb begin
    st_d = st_q;
    st_d.matchPrev = matchEq;

    // Control nibble; clear bit is not stored
    if (ctrlWr) begin
      st_d.countRunFlag = rfWrData[RUN_BIT]; // R2
      st_d.tickSourceSel = tick_src_t'(rfWrData[SEL_HI_BIT:SEL_LO_BIT]); // R4
    end

    // Counter changes only by clearing or counting
    if (clearHit) begin // R6
      st_d.count = COUNT_RESET; // R3
    end else if (advance) begin
      if (st_q.count == st_q.limit) begin
        st_d.count = COUNT_RESET; // R16
      end else begin
        st_d.count = st_q.count + 8'h01; // R15
      end
    end

    if (peripheralWriteOp && (periphAddr == PERIPH_LIMIT_ADDR)) begin
      st_d.limit = transferBufferIn; // R7
    end

    // Set wins over any clear in the same cycle
    if (irqWr) begin
      st_d.irq = rfWrData[IRQ_BIT];
    end
    if (clearHit) begin
      st_d.irq = 1'b0; // R14
    end
    if (matchSet) begin
      st_d.irq = 1'b1; // R9
    end

    if (rfRdEn) begin
      unique case (rfAddr)
        RF_CTRL_ADDR: st_d.rfRd = {st_q.countRunFlag, 1'b0, st_q.tickSourceSel}; // R14
        RF_IRQ_ADDR:  st_d.rfRd = {3'h0, st_q.irq};
        default:      st_d.rfRd = 4'h0;
      endcase
    end

    if (peripheralReadOp) begin
      unique case (periphAddr)
        PERIPH_COUNT_ADDR: st_d.periphRd = st_q.count; // R5
        default:           st_d.periphRd = 8'h00; // R8
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_q.count <= COUNT_RESET; // R10
      st_q.limit <= LIMIT_RESET; // R11
      st_q.countRunFlag <= CTRL_RESET[RUN_BIT];
      st_q.tickSourceSel <= SRC_DIV32;
      st_q.irq <= 1'b0;
      st_q.matchPrev <= 1'b0;
      st_q.rfRd <= 4'h0;
      st_q.periphRd <= 8'h00;
    end else begin
      st_q <= st_d;
    end
  end

  assign rfRdData = st_q.rfRd;
  assign transferBufferOut = st_q.periphRd;
  assign timerMatchIrqFlag = st_q.irq; // R17

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  chk_count_step: assert property ( // R15
    advance && !clearHit && (st_q.count != st_q.limit)
      |=> st_q.count == $past(st_q.count) + 8'h01)
    else $error("counter did not step on tick");

  chk_count_wrap: assert property ( // R16
    advance && !clearHit && (st_q.count == st_q.limit) |=> st_q.count == 8'h00)
    else $error("counter did not wrap after match");

  chk_count_halt: assert property ( // R2
    !st_q.countRunFlag && !clearHit |=> $stable(st_q.count))
    else $error("counter moved while stopped");

  chk_count_noload: assert property ( // R6
    peripheralWriteOp && (periphAddr == PERIPH_COUNT_ADDR) && !advance && !clearHit
      |=> $stable(st_q.count))
    else $error("counter loaded by software");

  chk_clear_both: assert property ( // R14
    clearHit && !matchSet |=> (st_q.count == 8'h00) && !timerMatchIrqFlag)
    else $error("clear flag missed counter or flag");

  chk_irq_set: assert property ( // R9
    advance && !clearHit && (st_q.count + 8'h01 == st_q.limit)
      && (st_q.count != st_q.limit) |=> ##1 timerMatchIrqFlag)
    else $error("match did not raise flag");

  chk_irq_sticky: assert property ( // R17
    timerMatchIrqFlag && !clearHit && !irqWr |=> timerMatchIrqFlag)
    else $error("flag dropped without clear");

  chk_zero_limit: assert property ( // R9
    (st_q.limit == 8'h00) && !timerMatchIrqFlag && !irqWr |=> !timerMatchIrqFlag)
    else $error("zero limit raised flag");

  chk_limit_load: assert property ( // R7
    peripheralWriteOp && (periphAddr == PERIPH_LIMIT_ADDR)
      |=> st_q.limit == $past(transferBufferIn))
    else $error("limit not loaded");

  chk_count_read: assert property ( // R5
    peripheralReadOp && (periphAddr == PERIPH_COUNT_ADDR)
      |=> transferBufferOut == $past(st_q.count))
    else $error("wrong counter read value");

  chk_limit_hidden: assert property ( // R8
    peripheralReadOp && (periphAddr == PERIPH_LIMIT_ADDR) |=> transferBufferOut == 8'h00)
    else $error("limit value leaked on read");

  chk_ctrl_read: assert property ( // R14
    rfRdEn && (rfAddr == RF_CTRL_ADDR) |=> !rfRdData[CLEAR_BIT])
    else $error("clear bit read as one");

  chk_run_write: assert property ( // R2
    ctrlWr |=> st_q.countRunFlag == $past(rfWrData[RUN_BIT]))
    else $error("run flag not written");

  chk_sel_write: assert property ( // R4
    ctrlWr |=> st_q.tickSourceSel == $past(rfWrData[SEL_HI_BIT:SEL_LO_BIT]))
    else $error("tick select not written");

  chk_ctrl_hold: assert property ( // R2
    !ctrlWr |=> $stable(st_q.countRunFlag) && $stable(st_q.tickSourceSel))
    else $error("control nibble changed without write");

  chk_clear_count: assert property ( // R3
    clearHit |=> st_q.count == COUNT_RESET)
    else $error("clear flag missed counter");

  chk_count_gate: assert property ( // R6
    !advance && !clearHit |=> $stable(st_q.count))
    else $error("counter moved without tick or clear");

  chk_limit_hold: assert property ( // R7
    !(peripheralWriteOp && (periphAddr == PERIPH_LIMIT_ADDR))
      |=> $stable(st_q.limit))
    else $error("limit changed without write");

  chk_irq_edge: assert property ( // R9
    matchSet |=> timerMatchIrqFlag)
    else $error("match edge did not raise flag");

  chk_irq_swclear: assert property ( // R17
    irqWr && !rfWrData[IRQ_BIT] && !matchSet
      |=> !timerMatchIrqFlag)
    else $error("software clear of flag lost");

  chk_irq_read: assert property ( // R9
    rfRdEn && (rfAddr == RF_IRQ_ADDR)
      |=> rfRdData == {3'h0, $past(timerMatchIrqFlag)})
    else $error("wrong flag read value");

  // Read path: unmapped reads give zero, data holds between reads
  chk_rf_unmapped: assert property ( // R1
    rfRdEn && (rfAddr != RF_CTRL_ADDR) && (rfAddr != RF_IRQ_ADDR)
      |=> rfRdData == 4'h0)
    else $error("unmapped nibble read not zero");

  chk_rf_hold: assert property ( // R14
    !rfRdEn |=> $stable(rfRdData))
    else $error("nibble read data changed without read");

  chk_periph_unmapped: assert property ( // R8
    peripheralReadOp && (periphAddr != PERIPH_COUNT_ADDR)
      |=> transferBufferOut == 8'h00)
    else $error("non-counter read not zero");

  chk_rd_hold: assert property ( // R5
    !peripheralReadOp |=> $stable(transferBufferOut))
    else $error("buffer read data changed without read");

  chk_tap_32: assert property ( // R13
    tapFall[0] |-> ##32 tapFall[0])
    else $error("fx/32 tap period wrong");

  chk_tap_64: assert property ( // R13
    tapFall[1] |-> ##64 tapFall[1])
    else $error("fx/64 tap period wrong");

  chk_tap_256: assert property ( // R13
    tapFall[2] |-> ##256 tapFall[2])
    else $error("fx/256 tap period wrong");

  chk_carrier_tick: assert property ( // R15
    (tk.sel == SRC_CARRIER) && tk.tick
      |-> !carrierIn && $past(carrierIn))
    else $error("carrier tick without falling edge");

  cov_wrap: cover property (advance && (st_q.count == st_q.limit));
  cov_irq: cover property (matchSet ##1 timerMatchIrqFlag);
  cov_carrier: cover property (advance && (st_q.tickSourceSel == SRC_CARRIER));
  cov_clear: cover property (clearHit && timerMatchIrqFlag);
  cov_sw_clear: cover property (irqWr && timerMatchIrqFlag);
endmodule // eight_bit_modulo_timer

// ### eight_bit_modulo_timer_tb.sv
/*
  Self-checking bench for the modulo timer: register-file and
  transfer-buffer accesses, tick sources and the match flag.
  Assumes timer_pkg and the design files are compiled first.
*/
module eight_bit_modulo_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import timer_pkg::*;

  logic                     core_clk          = 1'b0;
  logic                     rstn              = 1'b0;
  logic [RF_ADDR_W-1:0]     rfAddr            = '0;
  logic                     rfWrEn            = 1'b0;
  logic [RF_DATA_W-1:0]     rfWrData          = '0;
  logic                     rfRdEn            = 1'b0;
  logic [RF_DATA_W-1:0]     rfRdData;
  logic [PERIPH_ADDR_W-1:0] periphAddr        = '0;
  logic                     peripheralWriteOp = 1'b0;
  logic                     peripheralReadOp  = 1'b0;
  logic [CNT_W-1:0]         transferBufferIn  = '0;
  logic [CNT_W-1:0]         transferBufferOut;
  logic                     carrierIn         = 1'b0;
  logic                     timerMatchIrqFlag;
  int                       nMismatch         = 0;
  int                       comparisons       = 0;
  int                       seed              = 32'hD4F7;
  int                       i;
  int                       p;
  int                       falls;
  logic [3:0]               q;
  logic [7:0]               v;
  logic [7:0]               w;
  logic [7:0]               lim;
  logic                     b;
  logic                     prev;

  always #5 core_clk = ~core_clk;

  eight_bit_modulo_timer u_eight_bit_modulo_timer (
    .core_clk          (core_clk),
    .rstn              (rstn),
    .rfAddr            (rfAddr),
    .rfWrEn            (rfWrEn),
    .rfWrData          (rfWrData),
    .rfRdEn            (rfRdEn),
    .rfRdData          (rfRdData),
    .periphAddr        (periphAddr),
    .peripheralWriteOp (peripheralWriteOp),
    .peripheralReadOp  (peripheralReadOp),
    .transferBufferIn  (transferBufferIn),
    .transferBufferOut (transferBufferOut),
    .carrierIn         (carrierIn),
    .timerMatchIrqFlag (timerMatchIrqFlag)
  );

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      nMismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrapUp();
    $display("comparisons %0d mismatches %0d", comparisons, nMismatch);
    if (nMismatch == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Tick period in core_clk cycles for each prescaler code
  function automatic logic [15:0] expPeriod(input int code);
    return (code == 0) ? 16'h0020 : (code == 1) ? 16'h0040 : 16'h0100;
  endfunction

  // Control nibble as read back: clear bit always zero
  function automatic logic [15:0] expCtrl(input logic [3:0] wr);
    return {12'h000, wr[3], 1'b0, wr[1:0]};
  endfunction

  // One register-file access; read data lands one edge later
  task automatic rfAcc(input logic wr, input logic [5:0] a, input logic [3:0] d,
                       output logic [3:0] r);
    @(posedge core_clk);
    #1;
    rfAddr = a;
    rfWrData = d;
    rfWrEn = wr;
    rfRdEn = !wr;
    @(posedge core_clk);
    #1;
    rfWrEn = 1'b0;
    rfRdEn = 1'b0;
    r = rfRdData;
  endtask

  task automatic pAcc(input logic wr, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] r);
    @(posedge core_clk);
    #1;
    periphAddr = a;
    transferBufferIn = d;
    peripheralWriteOp = wr;
    peripheralReadOp = !wr;
    @(posedge core_clk);
    #1;
    peripheralWriteOp = 1'b0;
    peripheralReadOp = 1'b0;
    r = transferBufferOut;
  endtask

  // Cycles between two successive count changes
  task automatic period(output int n);
    int t1;
    pAcc(1'b0, PERIPH_COUNT_ADDR, 8'h00, v);
    w = v;
    for (i = 0; i < 200 && v === w; i++) pAcc(1'b0, PERIPH_COUNT_ADDR, 8'h00, w);
    t1 = int'($time);
    v = w;
    for (i = 0; i < 200 && v === w; i++) pAcc(1'b0, PERIPH_COUNT_ADDR, 8'h00, w);
    n = int'(($time - t1) / 10);
  endtask

  // Flag is looked at after the edge has settled; running out counts as a mismatch
  task automatic waitIrq(input int maxCyc);
    for (i = 0; i < maxCyc && timerMatchIrqFlag !== 1'b1; i++) begin
      @(posedge core_clk);
      #1;
    end
    check("irq wait", 16'(timerMatchIrqFlag), 16'h0001);
  endtask

  initial begin
    fork
      begin
        #300_000;
        nMismatch++;
        $display("watchdog expired");
        wrapUp();
      end
    join_none
    repeat (10) @(posedge core_clk);
    #1;
    rstn = 1'b1;
    rfAcc(1'b0, RF_CTRL_ADDR, 4'h0, q);
    check("ctrl reset", 16'(q), expCtrl(CTRL_RESET));
    pAcc(1'b0, PERIPH_COUNT_ADDR, 8'h00, v);
    check("count reset", 16'(v), 16'h0000);
    pAcc(1'b0, PERIPH_LIMIT_ADDR, 8'h00, v);
    check("limit read", 16'(v), 16'h0000);
    rfAcc(1'b0, 6'h10, 4'h0, q);
    check("rf unmapped", 16'(q), 16'h0000);
    pAcc(1'b0, 8'h40, 8'h00, v);
    check("periph unmapped", 16'(v), 16'h0000);
    waitIrq(9000);
    pAcc(1'b0, PERIPH_COUNT_ADDR, 8'h00, v);
    check("match at reset limit", 16'(v), 16'h00FF);
    pAcc(1'b1, PERIPH_COUNT_ADDR, 8'h5A, v);
    pAcc(1'b0, PERIPH_COUNT_ADDR, 8'h00, v);
    check("count load ignored", 16'(v), 16'h00FF);
    $display("reset test done");

    rfAcc(1'b1, RF_CTRL_ADDR, 4'h4, q);
    check("irq cleared", 16'(timerMatchIrqFlag), 16'h0001 ^ 16'h0001);
    pAcc(1'b0, PERIPH_COUNT_ADDR, 8'h00, v);
    check("count cleared", 16'(v), 16'h0000);
    lim = 8'h01 + 8'($random(seed) & 7);
    pAcc(1'b1, PERIPH_LIMIT_ADDR, lim, v);
    rfAcc(1'b1, RF_CTRL_ADDR, 4'h8, q);
    waitIrq(600);
    pAcc(1'b0, PERIPH_COUNT_ADDR, 8'h00, v);
    check("count at match", 16'(v), 16'(lim));
    repeat (40) @(posedge core_clk);
    pAcc(1'b0, PERIPH_COUNT_ADDR, 8'h00, v);
    check("wrap after match", 16'(v), 16'h0000);
    rfAcc(1'b1, RF_CTRL_ADDR, 4'h0, q);
    pAcc(1'b0, PERIPH_COUNT_ADDR, 8'h00, v);
    repeat (200) @(posedge core_clk);
    pAcc(1'b0, PERIPH_COUNT_ADDR, 8'h00, w);
    check("stopped count", 16'(w), 16'(v));
    check("irq sticky", 16'(timerMatchIrqFlag), 16'h0001);
    rfAcc(1'b0, RF_IRQ_ADDR, 4'h0, q);
    check("irq read", 16'(q), 16'h0001);
    rfAcc(1'b1, RF_IRQ_ADDR, 4'h0, q);
    check("irq sw clear", 16'(timerMatchIrqFlag), 16'h0000);
    $display("match test done");

    pAcc(1'b1, PERIPH_LIMIT_ADDR, 8'hFF, v);
    for (int s = 0; s < 3; s++) begin
      rfAcc(1'b1, RF_CTRL_ADDR, {2'b10, 2'(s)}, q);
      rfAcc(1'b0, RF_CTRL_ADDR, 4'h0, q);
      check("select readback", 16'(q), expCtrl({2'b10, 2'(s)}));
      period(p);
      check("tick period", 16'(p), expPeriod(s));
    end
    $display("select test done");

    rfAcc(1'b1, RF_CTRL_ADDR, 4'h7, q);
    rfAcc(1'b1, RF_CTRL_ADDR, 4'hB, q);
    falls = 0;
    prev = 1'b0;
    repeat (60) begin
      @(posedge core_clk);
      #1;
      b = 1'($random(seed));
      if (prev && !b) falls++;
      carrierIn = b;
      prev = b;
    end
    repeat (4) @(posedge core_clk);
    pAcc(1'b0, PERIPH_COUNT_ADDR, 8'h00, v);
    check("carrier ticks", 16'(v), 16'(falls));
    $display("carrier test done");

    // Reset in mid-run brings back the reset state
    rstn = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    check("irq in reset", 16'(timerMatchIrqFlag), 16'h0000);
    rstn = 1'b1;
    rfAcc(1'b0, RF_CTRL_ADDR, 4'h0, q);
    check("ctrl after reset", 16'(q), expCtrl(CTRL_RESET));
    pAcc(1'b0, PERIPH_COUNT_ADDR, 8'h00, v);
    check("count after reset", 16'(v), 16'h0000);
    $display("mid-run reset test done");
    wrapUp();
  end
endmodule // eight_bit_modulo_timer_tb
